// ===== core/soft_cfg.sv
/*
  Mode decoder and serial configuration register. Classifies the four
  select pins against the device clock, receives the 40-bit word in soft
  mode and presents the effective configuration.
  Assumes the device clock is much slower than the system clock (at least
  eight system cycles per half period) and runs freely.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defines.svh"

module soft_cfg
  import cfg_pkg::*;
(
  input  wire logic     CLK_SYS_IN,          // System clock, 125 MHz
  input  wire logic     RSTN_IN,             // Async reset, active low
  input  wire logic     DEV_CLK_IN,          // Device clock pin
  input  wire logic     MODE_SELECT_PIN_A_IN,// Strap / serial clock
  input  wire logic     MODE_SELECT_PIN_B_IN,// Strap / serial data
  input  wire logic     MODE_SELECT_PIN_C_IN,// Strap / serial enable
  input  wire logic     MODE_SELECT_PIN_D_IN,// Strap / soft select
  output cfg_fields_type CONFIG_OUT,         // Effective configuration
  output logic          SOFT_MODE_OUT,       // High in soft mode
  output logic          LOAD_DONE_OUT        // Pulse: word applied
);

  logic [`PIN_COUNT-1:0] pins_sync;
  logic [`PIN_COUNT-1:0] prev_reg;
  logic [`PIN_COUNT-1:0] prev_next;
  logic [3:0]            rise_smp_reg;
  logic [3:0]            rise_smp_next;
  pin_mode_type          pin_mode_reg [4];
  pin_mode_type          pin_mode_next [4];
  logic [1:0]            stable_cnt_reg;
  logic [1:0]            stable_cnt_next;
  logic                  soft_reg;
  logic                  soft_next;
  ser_state_type         state_reg;
  ser_state_type         state_next;
  logic [5:0]            bit_cnt_reg;
  logic [5:0]            bit_cnt_next;
  logic [`CFG_WIDTH-1:0] shift_reg;
  logic [`CFG_WIDTH-1:0] shift_next;
  cfg_fields_type        soft_word_reg;
  cfg_fields_type        soft_word_next;
  logic                  load_reg;
  logic                  load_next;
  cfg_fields_type        hard_word;
  cfg_fields_type        config_reg;
  cfg_fields_type        config_next;
  logic                  clk_rise;
  logic                  clk_fall;
  logic                  sclk_rise;
  logic                  ser_en;
  logic                  ser_data;

  // All pins cross into the system domain first
  pin_sync #(
    .WIDTH (`PIN_COUNT)
  ) u_pin_sync (
    .clk_in   (CLK_SYS_IN),
    .rstn_in  (RSTN_IN),
    .raw_in   ({DEV_CLK_IN, MODE_SELECT_PIN_D_IN, MODE_SELECT_PIN_C_IN,
                MODE_SELECT_PIN_B_IN, MODE_SELECT_PIN_A_IN}),
    .sync_out (pins_sync)
  );

  // Edges of the synchronised device clock and serial clock
  assign clk_rise  = pins_sync[`PIN_DEVCLK] & ~prev_reg[`PIN_DEVCLK];
  assign clk_fall  = ~pins_sync[`PIN_DEVCLK] & prev_reg[`PIN_DEVCLK];
  assign sclk_rise = pins_sync[`PIN_SCLK] & ~prev_reg[`PIN_SCLK];
  assign ser_en    = pins_sync[`PIN_SEN];
  assign ser_data  = pins_sync[`PIN_SDATA];

  // Pin classes: sample at clock rise, classify at clock fall. Both paths
  // share the same synchroniser delay, so a pin tied to the clock reads
  // high at the rise and low at the fall.
  always_comb begin
    prev_next       = pins_sync;
    rise_smp_next   = rise_smp_reg;
    pin_mode_next   = pin_mode_reg;
    stable_cnt_next = stable_cnt_reg;
    soft_next       = soft_reg;
    if (clk_rise) begin
      rise_smp_next = pins_sync[3:0];
    end
    if (clk_fall) begin
      for (int i = 0; i < 4; i++) begin
        pin_mode_next[i] = pin_mode_type'({pins_sync[i], rise_smp_reg[i]});
      end
      // Mode switches only after the class has held for several clocks
      if (pin_mode_next[`PIN_MODESEL] != pin_mode_reg[`PIN_MODESEL]) begin
        stable_cnt_next = 2'h0;
      end else if (stable_cnt_reg != `MODE_STABLE_CLKS) begin
        stable_cnt_next = stable_cnt_reg + 2'h1;
      end
      if (stable_cnt_next == `MODE_STABLE_CLKS) begin
        soft_next = (pin_mode_next[`PIN_MODESEL] == PIN_CLK);
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      prev_reg       <= '0;
      rise_smp_reg   <= 4'h0;
      pin_mode_reg   <= '{default: PIN_GND};
      stable_cnt_reg <= 2'h0;
      soft_reg       <= 1'b0;
    end else begin
      prev_reg       <= prev_next;
      rise_smp_reg   <= rise_smp_next;
      pin_mode_reg   <= pin_mode_next;
      stable_cnt_reg <= stable_cnt_next;
      soft_reg       <= soft_next;
    end
  end

  // Serial receiver. A frame that is not exactly 40 bits is dropped, so
  // a broken transfer can never leave a half-written configuration.
  always_comb begin
    state_next     = state_reg;
    bit_cnt_next   = bit_cnt_reg;
    shift_next     = shift_reg;
    soft_word_next = soft_word_reg;
    load_next      = 1'b0;
    case (state_reg)
      SER_IDLE: begin
        if (soft_reg && ser_en) begin
          state_next   = SER_SHIFT;
          bit_cnt_next = 6'h00;
        end
      end
      SER_SHIFT: begin
        if (!soft_reg) begin
          state_next = SER_IDLE;
        end else if (!ser_en) begin
          state_next = SER_IDLE;
          if (bit_cnt_reg == `CFG_BITS_LOADED) begin
            soft_word_next = cfg_fields_type'(shift_reg);
            load_next      = 1'b1;
          end
        end else if (sclk_rise) begin
          shift_next = {shift_reg[`CFG_WIDTH-2:0], ser_data};
          if (bit_cnt_reg != `BIT_CNT_MAX) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
          end
        end
      end
      default: begin
        state_next = SER_IDLE;
      end
    endcase
  end

  // Stored word changes only on a complete frame
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_reg     <= SER_IDLE;
      bit_cnt_reg   <= 6'h00;
      shift_reg     <= '0;
      soft_word_reg <= cfg_fields_type'(`CFG_RESET);
      load_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      bit_cnt_reg   <= bit_cnt_next;
      shift_reg     <= shift_next;
      soft_word_reg <= soft_word_next;
      load_reg      <= load_next;
    end
  end

  // Hard-mode word decoded from the strap classes
  always_comb begin
    hard_word = cfg_fields_type'(`HARD_FIXED);
    case (pin_mode_reg[0])
      PIN_GND: begin
        hard_word.precision_select = 1'b0;
        hard_word.current_gain     = 2'h3;
      end
      PIN_CLK: begin
        hard_word.precision_select = 1'b0;
        hard_word.current_gain     = 2'h0;
      end
      PIN_NCLK: begin
        hard_word.precision_select = 1'b1;
        hard_word.current_gain     = 2'h0;
      end
      default: begin
        hard_word.precision_select = 1'b1;
        hard_word.current_gain     = 2'h3;
      end
    endcase
    hard_word.ref_temp_curve = pin_mode_reg[1];
    case (pin_mode_reg[2])
      PIN_GND: begin
        hard_word.output_mux_enable     = 1'b1;
        hard_word.voltage_mod_powerdown = 1'b0;
      end
      PIN_CLK, PIN_NCLK: begin
        hard_word.output_mux_enable     = 1'b0;
        hard_word.voltage_mod_powerdown = 1'b1;
      end
      default: begin
        hard_word.output_mux_enable     = 1'b0;
        hard_word.voltage_mod_powerdown = 1'b0;
      end
    endcase
    // Self-test swaps the input pins for the test DAC
    hard_word.current_selftest_enable =
      (pin_mode_reg[`PIN_MODESEL] == PIN_VCC);
    hard_word.voltage_selftest_enable =
      (pin_mode_reg[`PIN_MODESEL] == PIN_VCC);
    hard_word.current_input_enable =
      (pin_mode_reg[`PIN_MODESEL] != PIN_VCC);
    hard_word.voltage_input_enable =
      (pin_mode_reg[`PIN_MODESEL] != PIN_VCC);
  end

  // Soft mode passes every stored field straight through: choppers,
  // dither and output selector
  always_comb begin
    config_next = soft_reg ? soft_word_reg : hard_word;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      config_reg <= cfg_fields_type'(`HARD_FIXED);
    end else begin
      config_reg <= config_next;
    end
  end

  assign CONFIG_OUT    = config_reg;
  assign SOFT_MODE_OUT = soft_reg;
  assign LOAD_DONE_OUT = load_reg;

  // Checks on the receiver and the output selection
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence frame_full;
    state_reg == SER_SHIFT && soft_reg && !ser_en &&
    bit_cnt_reg == `CFG_BITS_LOADED;
  endsequence

  sequence frame_short;
    state_reg == SER_SHIFT && !ser_en &&
    bit_cnt_reg != `CFG_BITS_LOADED;
  endsequence

  sequence shift_step;
    state_reg == SER_SHIFT && soft_reg && ser_en && sclk_rise &&
    bit_cnt_reg < 6'h28;
  endsequence

  full_frame_load_a: assert property (
    frame_full |=> load_reg && soft_word_reg == $past(shift_reg)
  ) else $error("full frame not applied");

  short_frame_drop_a: assert property (
    frame_short |=> !load_reg ##0 $stable(soft_word_reg)
  ) else $error("short frame changed the word");

  word_hold_a: assert property (
    !load_next |=> $stable(soft_word_reg)
  ) else $error("stored word changed without a frame");

  bit_shift_a: assert property (
    shift_step |=> bit_cnt_reg == $past(bit_cnt_reg) + 6'h01 &&
                   shift_reg[0] == $past(ser_data)
  ) else $error("serial bit not taken");

  soft_output_a: assert property (
    soft_reg && soft_next |=> ##1 CONFIG_OUT == $past(soft_word_reg)
  ) else $error("soft word not on output");

  hard_fixed_a: assert property (
    !soft_reg |=> (CONFIG_OUT & `HARD_FIXED_MASK) == `HARD_FIXED
  ) else $error("hard mode upper bits wrong");

  hard_gain_a: assert property (
    !soft_reg && pin_mode_reg[0] == PIN_GND |=>
      CONFIG_OUT[`POS_GAIN_LSB+:2] == 2'h3 && !CONFIG_OUT[`POS_PRECISION]
  ) else $error("hard gain decode wrong");

  hard_curve_a: assert property (
    !soft_reg |=> CONFIG_OUT[`POS_TC_LSB+:2] == $past(pin_mode_reg[1])
  ) else $error("hard curve decode wrong");

  mode_change_a: assert property (
    soft_reg != $past(soft_reg) |-> $past(clk_fall) &&
      soft_reg == ($past(pin_mode_next[`PIN_MODESEL]) == PIN_CLK)
  ) else $error("mode changed off a clock fall");

  load_pulse_a: assert property (
    load_reg |=> !load_reg [*2]
  ) else $error("load pulse too long");

endmodule

`default_nettype wire

// ===== core/cfg_defines.svh
/*
  Constants of the soft-mode serial configuration block: field positions,
  reset and fixed values, pin indices and counts. Definitions only; the
  configuration module and the test bench include it by its bare name.
*/
// Notes on behaviour
// - Fourth select pin clocked means soft mode.
// - Soft mode: pins carry clock, data, enable.
// - Forty configuration bits, all serially writable.
// - Bits hold until a new write replaces.
// - Bit 0 selects low or high precision.
// - Bits 1-2 set current gain 2-16.
// - Bits 3-4 select reference temperature curve.
// - Bit 5 multiplexes both modulator outputs.
// - Bit 6 powers down voltage modulator.
// - Bit 7 enables current self-test DAC.
// - Bit 8 enables voltage self-test DAC.
// - Bit 9 connects current input pins.
// - Bit 10 connects voltage input pins.
// - Bits 11-14 current low-frequency chopper.
// - Bits 15-18 current high-frequency chopper.
// - Bits 19-22 voltage low-frequency chopper.
// - Bits 23-26 voltage high-frequency chopper.
// - Bit 27 enables current dither.
// - Bit 28 enables voltage dither.
// - Bits 32-37 output selector; others reserved.
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH

`define CFG_WIDTH        40
`define CFG_BITS_LOADED  6'h28
`define BIT_CNT_MAX      6'h3F
`define CFG_RESET        40'h001B9B9800
`define HARD_FIXED       40'h001B9B9800
`define HARD_FIXED_MASK  40'hFFFFFFF800
`define MODE_STABLE_CLKS 2'h2

`define POS_PRECISION    0
`define POS_GAIN_LSB     1
`define POS_TC_LSB       3
`define POS_SELECT_LSB   32

`define PIN_SCLK         0
`define PIN_SDATA        1
`define PIN_SEN          2
`define PIN_MODESEL      3
`define PIN_DEVCLK       4
`define PIN_COUNT        5

`endif

// ===== core/cfg_pkg.sv
/*
  Types of the soft-mode serial configuration block: the configuration
  word as a packed struct, pin level classes and receiver states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package cfg_pkg;

  // Level seen on a select pin, relative to the device clock
  typedef enum logic [1:0] {
    PIN_GND  = 2'b00,
    PIN_CLK  = 2'b01,
    PIN_NCLK = 2'b10,
    PIN_VCC  = 2'b11
  } pin_mode_type;

  typedef enum logic {
    SER_IDLE  = 1'b0,
    SER_SHIFT = 1'b1
  } ser_state_type;

  // Configuration word, bit 39 first
  typedef struct packed {
    logic [1:0] reserved_top;
    logic [5:0] output_signal_select;
    logic [2:0] reserved_mid;
    logic       voltage_dither_enable;
    logic       current_dither_enable;
    logic [2:0] voltage_highfreq_chop_rate;
    logic       voltage_highfreq_chop_enable;
    logic [2:0] voltage_lowfreq_chop_rate;
    logic       voltage_lowfreq_chop_enable;
    logic [2:0] current_highfreq_chop_rate;
    logic       current_highfreq_chop_enable;
    logic [2:0] current_lowfreq_chop_rate;
    logic       current_lowfreq_chop_enable;
    logic       voltage_input_enable;
    logic       current_input_enable;
    logic       voltage_selftest_enable;
    logic       current_selftest_enable;
    logic       voltage_mod_powerdown;
    logic       output_mux_enable;
    logic [1:0] ref_temp_curve;
    logic [1:0] current_gain;
    logic       precision_select;
  } cfg_fields_type;

endpackage

`default_nettype wire

// ===== core/pin_sync.sv
/*
  Two-flop synchroniser, one chain per bit. Inputs are asynchronous
  pins; outputs are safe to use in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clk_in,   // System clock
  input  wire logic             rstn_in,  // Async reset, active low
  input  wire logic [WIDTH-1:0] raw_in,   // Pins from outside
  output logic      [WIDTH-1:0] sync_out  // Synchronised copies
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First flop feeds only the second, never any logic
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        meta_reg[g] <= 1'b0;
        sync_reg[g] <= 1'b0;
      end else begin
        meta_reg[g] <= raw_in[g];
        sync_reg[g] <= meta_reg[g];
      end
    end
  end

  assign sync_out = sync_reg;

endmodule

`default_nettype wire

// ===== tb/cfg_ctrl_model.sv
/*
  Controller model for the select pins: strap levels in hard mode and
  framed serial writes in soft mode.
  Assumes a free-running device clock and a system clock to pace edges.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_ctrl_model
  import cfg_pkg::*;
(
  input  wire logic clk_in,     // System clock, paces serial edges
  input  wire logic dev_clk_in, // Free-running device clock
  output logic      pin_a_out,  // Strap or serial clock
  output logic      pin_b_out,  // Strap or serial data
  output logic      pin_c_out,  // Strap or serial enable
  output logic      pin_d_out   // Strap or device clock
);
  pin_mode_type strap_a, strap_b, strap_c, strap_d;
  logic         serial_on, sclk, sdata, sen;

  // Pin level for a strap class
  function automatic logic lvl(input pin_mode_type m, input logic c);
    case (m)
      PIN_GND:  return 1'b0;
      PIN_CLK:  return c;
      PIN_NCLK: return ~c;
      default:  return 1'b1;
    endcase
  endfunction

  // Serial port borrows pins A-C; a clocked D selects soft mode
  assign pin_a_out = serial_on ? sclk : lvl(strap_a, dev_clk_in);
  assign pin_b_out = serial_on ? sdata : lvl(strap_b, dev_clk_in);
  assign pin_c_out = serial_on ? sen : lvl(strap_c, dev_clk_in);
  assign pin_d_out = lvl(strap_d, dev_clk_in);

  // Idle start: hard mode, all straps grounded, serial clock still
  initial begin
    strap_a   = PIN_GND;
    strap_b   = PIN_GND;
    strap_c   = PIN_GND;
    strap_d   = PIN_GND;
    serial_on = 1'b0;
    sclk      = 1'b0;
    sdata     = 1'b0;
    sen       = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // A mode switch keeps A-C still for three device clocks after D moves
  task automatic set_straps(input pin_mode_type a, b, c, d);
    logic swap;
    swap = (strap_d == PIN_CLK) != (d == PIN_CLK);
    strap_d = d;
    if (swap) repeat (3) @(posedge dev_clk_in);
    tick(1);
    serial_on = (d == PIN_CLK);
    sclk      = 1'b0;
    sen       = 1'b0;
    strap_a   = a;
    strap_b   = b;
    strap_c   = c;
  endtask

  // One frame, bit 39 first; the last cut bits are left off on purpose
  task automatic frame(input logic [39:0] word, input int cut,
                       input int half);
    int i;
    tick(half);
    sen = 1'b1;
    tick(half);
    for (i = 39; i >= cut; i--) begin
      sdata = word[i];
      tick(half);
      sclk = 1'b1;
      tick(half);
      sclk = 1'b0;
    end
    tick(half);
    sen   = 1'b0;
    sdata = ~sdata; // A released line must not keep the last bit
  endtask
endmodule

`default_nettype wire

// ===== tb/soft_mode_serial_config_test.sv
/*
  Self-checking bench for the soft-mode configuration block: strap
  decode, serial writes, dropped frames, mode glitches and resets.
  Assumes the controller model drives all four select pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfg_defines.svh"

module soft_mode_serial_config_test
  import cfg_pkg::*;
;
  typedef struct packed {
    pin_mode_type a, b, c, d;
    logic [10:0]  low;
  } row_type;

  logic           clk_sys, rstn, dev_clk;
  logic           pin_a, pin_b, pin_c, pin_d, soft_mode, load_done;
  cfg_fields_type config_word;
  int             err_count = 0, checks_done = 0, load_pulses = 0;
  int             cycles = 0, r;

  // Strap classes beside the low eleven bits they decode to
  row_type rows [4] = '{
    '{PIN_GND,  PIN_GND,  PIN_GND,  PIN_GND,  11'h626},
    '{PIN_CLK,  PIN_CLK,  PIN_CLK,  PIN_VCC,  11'h1C8},
    '{PIN_NCLK, PIN_NCLK, PIN_NCLK, PIN_GND,  11'h651},
    '{PIN_VCC,  PIN_VCC,  PIN_VCC,  PIN_NCLK, 11'h61F}
  };
  // Reserved bits written as zero; patterns cover every gain and curve
  logic [39:0] words [4] = '{40'h3F1FFFFFFF, 40'h0000000000,
                             40'h2A0AAAAAAA, 40'h1515555555};

  cfg_ctrl_model ctrl (.clk_in(clk_sys), .dev_clk_in(dev_clk),
    .pin_a_out(pin_a), .pin_b_out(pin_b), .pin_c_out(pin_c),
    .pin_d_out(pin_d));
  soft_cfg uut (.CLK_SYS_IN(clk_sys), .RSTN_IN(rstn), .DEV_CLK_IN(dev_clk),
    .MODE_SELECT_PIN_A_IN(pin_a), .MODE_SELECT_PIN_B_IN(pin_b),
    .MODE_SELECT_PIN_C_IN(pin_c), .MODE_SELECT_PIN_D_IN(pin_d),
    .CONFIG_OUT(config_word), .SOFT_MODE_OUT(soft_mode),
    .LOAD_DONE_OUT(load_done));

  // Clocks; device clock edges sit between system clock rising edges
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    dev_clk = 1'b0;
    #37;
    forever #80 dev_clk = ~dev_clk;
  end

  // Pulse counter and run limit; a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cycles++;
    if (load_done === 1'b1) load_pulses++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic cmp40(input string name, input logic [39:0] exp,
                       input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp1(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cmpn(input string name, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Mode detection needs three device-clock falls, so the wait is bounded
  task automatic wait_soft(input logic want);
    int i;
    for (i = 0; i < 400 && soft_mode !== want; i++) tick(1);
    tick(2);
    cmp1("soft mode", want, soft_mode);
  endtask

  // Counting pulses shows a one-cycle pulse per applied word, never more
  task automatic expect_load(input logic [39:0] w, input int n);
    int p;
    p = load_pulses;
    tick(12);
    cmpn("load pulses", p + n, load_pulses);
    cmp40("config", w, config_word);
  endtask

  task automatic check_hard(input int k);
    logic [39:0] hw;
    hw = `HARD_FIXED | {29'h0, rows[k].low};
    ctrl.set_straps(rows[k].a, rows[k].b, rows[k].c, rows[k].d);
    tick(160);
    cmp40("hard config", hw, config_word);
    cmp1("hard mode", 1'b0, soft_mode);
  endtask

  initial begin
    rstn = 1'b0;
    tick(2);
    cmp40("reset config", `CFG_RESET, config_word);
    cmp1("reset load", 1'b0, load_done);
    tick(1);
    rstn = 1'b1;
    for (r = 0; r < 4; r++) check_hard(r);
    // Soft mode shows the stored word, still at its reset value
    ctrl.set_straps(PIN_GND, PIN_GND, PIN_GND, PIN_CLK);
    wait_soft(1'b1);
    cmp40("stored word", `CFG_RESET, config_word);
    // Back-to-back frames at the fastest legal serial pace
    for (r = 0; r < 4; r++) begin
      ctrl.frame(words[r], 0, 4);
      expect_load(words[r], 1);
    end
    // Slow serial clock, then a frame one bit short that must be dropped
    ctrl.frame(40'h0C12345678, 0, 20);
    expect_load(40'h0C12345678, 1);
    ctrl.frame(40'h3000000001, 1, 4);
    expect_load(40'h0C12345678, 0);
    // D loses its clock for two device clocks: too short to leave
    ctrl.strap_d = PIN_GND;
    tick(40);
    ctrl.strap_d = PIN_CLK;
    tick(40);
    cmp1("soft after glitch", 1'b1, soft_mode);
    cmp40("config after glitch", 40'h0C12345678, config_word);
    // Hard mode forces upper bits; returning brings the stored word back
    check_hard(1);
    ctrl.set_straps(PIN_GND, PIN_GND, PIN_GND, PIN_CLK);
    wait_soft(1'b1);
    cmp40("kept word", 40'h0C12345678, config_word);
    // A reset in mid-run returns the stored word to its reset value as well
    rstn = 1'b0;
    tick(3);
    cmp40("reset config", `CFG_RESET, config_word);
    cmp1("reset soft", 1'b0, soft_mode);
    rstn = 1'b1;
    wait_soft(1'b1);
    cmp40("word after reset", `CFG_RESET, config_word);
    stop_test();
  end
endmodule

`default_nettype wire
